/* File: pkg/rt_ctrl_pkg.sv */
// Constants and types shared by the descriptor control-word logic
// How it works
// - Buffer mode priority: ping-pong, then circular 2, circular 1, else indexed.
// - Device confirms every ping-pong on/off change made while executing in the active acknowledge bit.
// - Enabled but unacknowledged ping-pong reuses the next-buffer bit, no toggle.
// - Next-buffer bit toggles after clean ping-pong messages only; resets clear it.
// - Mode commands use ping-pong, indexed or simplified buffering, never circular.
// - Simplified processing off: mode word ping-pong enable picks the buffering.
// - Simplified processing on: ping-pong enable ignored, no separate buffers.
// - Simplified processing stores mode codes 16 to 31 inside the descriptor.
// - Simplified processing leaves interrupt bits and behaviour untouched.
// - Receive mode word applies for receive commands to subaddress 0 or 31.
// - Bits 8 to 11 are host read-only; device updates them while executing.
// - Bit 2 host-writable only when not executing; bits 3, 12-15 always.
// - Master reset clears the whole mode control word.
// - Software reset clears only block-accessed, next-buffer, broadcast bits.
// - Host read of a control word clears its block-accessed bit.
// - Device sets block-accessed when it completes a message while executing.
package rt_ctrl_pkg;
  localparam int DATA_W = 16;
  localparam int BUS_W = 32;
  localparam int ADDR_W = 9;
  localparam int IDX_W = 7;
  localparam int MEM_AW = 6;
  localparam int SA_W = 5;
  // Word indexes, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_MODE_BASE = 7'h20;
  localparam logic [IDX_W-1:0] IDX_MEM_END = 7'h40;
  localparam logic [IDX_W-1:0] IDX_CFG = 7'h40;
  localparam logic [IDX_W-1:0] IDX_STAT = 7'h41;
  localparam logic [MEM_AW-1:0] MEM_LAST = 6'h3F;
  localparam logic [MEM_AW-1:0] MEM_FIRST = 6'h00;
  // Control word field positions
  localparam int B_CIR1 = 0;
  localparam int B_CIR2 = 1;
  localparam int B_PINGPONG_ENABLE = 2;
  localparam int B_PINGPONG_SUSPEND_REQUEST = 3;
  localparam int B_PINGPONG_ACTIVE_ACK = 8;
  localparam int B_BROADCAST_RECEIVED_FLAG = 9;
  localparam int B_DPB = 10;
  localparam int B_BLOCK_ACCESSED_FLAG = 11;
  localparam logic [DATA_W-1:0] HOST_RO_MASK = 16'h0F00;
  localparam logic [DATA_W-1:0] EXEC_LOCK_MASK = 16'h00F7;
  localparam logic [DATA_W-1:0] SOFTWARE_RESET_REQUEST_CLR_MASK = 16'h0E00;
  localparam logic [DATA_W-1:0] MR_WORD = 16'h0000;
  localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;
  localparam logic [DATA_W-1:0] CFG_RESET = 16'h0000;
  // Configuration bits
  localparam int C_SIMPLIFIED_MODE_PROCESSING = 0;
  localparam int C_EXEC = 1;
  localparam int C_SOFTWARE_RESET_REQUEST = 2;
  // Command decode
  localparam logic [SA_W-1:0] SA_MODE_LO = 5'h00;
  localparam logic [SA_W-1:0] SA_MODE_HI = 5'h1F;
  localparam logic [SA_W-1:0] MC_STORE_MIN = 5'h10;
  typedef enum logic [2:0] {
    BUF_INDEXED,
    BUF_CIRC1,
    BUF_CIRC2,
    BUF_PINGPONG,
    BUF_SIMPLIFIED
  } buf_mode_e;
endpackage

/* File: hw/ctrl_word_ram.sv */
// Single-port control word store with registered read data
`timescale 1ns/100ps
module ctrl_word_ram #(
  parameter int DW = 16,
  parameter int AW = 6
) (
  input wire logic ref_clk,
  input wire logic ce,
  input wire logic re,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // No reset: the owner sweeps the array clear after reset
  always_ff @(posedge ref_clk) begin
    if (ce && we) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (ce && re) begin
      rdata <= mem[addr];
    end
  end
endmodule

/* File: hw/rt_buffer_mode_control_word.sv */
// Descriptor control words: buffer mode select, ping-pong handshake, resets
`timescale 1ns/100ps
module rt_buffer_mode_control_word
  import rt_ctrl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [BUS_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [BUS_W-1:0] readdata,
  output logic waitrequest,
  input wire logic cmd_start,
  input wire logic cmd_tr,
  input wire logic [SA_W-1:0] cmd_sa,
  input wire logic [SA_W-1:0] cmd_mode_code,
  input wire logic msg_done,
  input wire logic msg_error,
  input wire logic msg_illegal,
  input wire logic msg_busy,
  input wire logic msg_broadcast_received_flag,
  output logic sel_valid,
  output buf_mode_e sel_mode,
  output logic sel_buffer_b,
  output logic sel_in_block,
  output logic sel_pingpong_live,
  output logic simplified_mode_processing,
  output logic execution_start
);

  typedef enum {
    S_IDLE, S_SWRD, S_SWWR, S_HRD, S_HWR, S_HACK, S_ERD, S_ELAT,
    S_DRD, S_DWR
  } state_e;

  state_e state_reg;
  logic [MEM_AW-1:0] sweep_idx_reg;
  logic clear_all_reg;
  logic software_reset_request_pend_reg;
  logic cmd_pend_reg;
  logic done_pend_reg;
  logic [MEM_AW-1:0] cmd_idx_reg;
  logic cmd_is_mode_reg;
  logic [SA_W-1:0] cmd_mc_reg;
  logic [3:0] done_flags_reg;
  logic msg_active_reg;
  logic [DATA_W-1:0] cfg_reg;
  logic [BUS_W-1:0] readdata_reg;
  buf_mode_e sel_mode_reg;
  logic sel_buffer_b_reg;
  logic sel_in_block_reg;
  logic sel_live_reg;

  logic mem_re;
  logic mem_we;
  logic [MEM_AW-1:0] mem_addr;
  logic [DATA_W-1:0] mem_wdata;
  logic [DATA_W-1:0] mem_rdata;
  logic [IDX_W-1:0] host_idx;
  logic host_req;
  logic host_mem;
  logic cmd_take;
  logic done_take;
  logic [DATA_W-1:0] keep_mask;
  logic [DATA_W-1:0] host_word;
  logic [DATA_W-1:0] done_word;
  logic is_mode_cmd;
  logic exec;
  logic toggle_ok;
  buf_mode_e lat_mode;

  assign host_idx = address[ADDR_W-1:2];
  assign host_req = read | write;
  assign host_mem = host_idx < IDX_MEM_END;
  assign exec = cfg_reg[C_EXEC];
  assign simplified_mode_processing = cfg_reg[C_SIMPLIFIED_MODE_PROCESSING];
  assign execution_start = exec;
  assign waitrequest = host_req && (state_reg != S_HACK);
  assign readdata = readdata_reg;
  assign sel_valid = msg_active_reg;
  assign sel_mode = sel_mode_reg;
  assign sel_buffer_b = sel_buffer_b_reg;
  assign sel_in_block = sel_in_block_reg;
  assign sel_pingpong_live = sel_live_reg;
  // Both mode subaddresses share one word per mode code
  assign is_mode_cmd = (cmd_sa == SA_MODE_LO) || (cmd_sa == SA_MODE_HI);
  assign cmd_take = (state_reg == S_IDLE) && !software_reset_request_pend_reg &&
                    !done_pend_reg && cmd_pend_reg;
  assign done_take = (state_reg == S_IDLE) && !software_reset_request_pend_reg &&
                     done_pend_reg;

  //////////////////////////////////////////////////////////////////////////
  // Host write merge: device-owned and locked bits keep their old value
  always_comb begin
    keep_mask = HOST_RO_MASK;
    if (exec) begin
      keep_mask = keep_mask | EXEC_LOCK_MASK;
    end
    keep_mask = keep_mask | ~{{8{byteenable[1]}}, {8{byteenable[0]}}};
    host_word = (mem_rdata & keep_mask) |
                (writedata[DATA_W-1:0] & ~keep_mask);
    if (exec) begin
      // Acknowledge a suspend or resume as soon as the host asks
      host_word[B_PINGPONG_ACTIVE_ACK] = host_word[B_PINGPONG_ENABLE] & ~host_word[B_PINGPONG_SUSPEND_REQUEST];
    end
  end

  // Completion write-back of the device-owned bits
  always_comb begin
    toggle_ok = (sel_mode_reg == BUF_PINGPONG) && sel_live_reg &&
                !done_flags_reg[0] && !done_flags_reg[1] &&
                !done_flags_reg[2];
    done_word = mem_rdata;
    if (exec) begin
      done_word[B_BLOCK_ACCESSED_FLAG] = 1'b1;
      if (toggle_ok) begin
        done_word[B_DPB] = ~mem_rdata[B_DPB];
      end
      if (done_flags_reg[3]) begin
        done_word[B_BROADCAST_RECEIVED_FLAG] = 1'b1;
      end
      done_word[B_PINGPONG_ACTIVE_ACK] = mem_rdata[B_PINGPONG_ENABLE] & ~mem_rdata[B_PINGPONG_SUSPEND_REQUEST];
    end
  end

  // Mode decode of the descriptor read at command start
  always_comb begin
    if (cmd_is_mode_reg) begin
      if (cfg_reg[C_SIMPLIFIED_MODE_PROCESSING]) begin
        // Only buffering changes; interrupt bits pass through untouched
        lat_mode = BUF_SIMPLIFIED;
      end else if (mem_rdata[B_PINGPONG_ENABLE]) begin
        lat_mode = BUF_PINGPONG;
      end else begin
        lat_mode = BUF_INDEXED;
      end
    end else if (mem_rdata[B_PINGPONG_ENABLE]) begin
      lat_mode = BUF_PINGPONG;
    end else if (mem_rdata[B_CIR2]) begin
      lat_mode = BUF_CIRC2;
    end else if (mem_rdata[B_CIR1]) begin
      lat_mode = BUF_CIRC1;
    end else begin
      lat_mode = BUF_INDEXED;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Memory port steering
  always_comb begin
    mem_re = 1'b0;
    mem_we = 1'b0;
    mem_addr = cmd_idx_reg;
    mem_wdata = mem_rdata;
    case (state_reg)
      S_IDLE: begin
        if (software_reset_request_pend_reg) begin
          mem_addr = MEM_FIRST;
        end else if (done_pend_reg || cmd_pend_reg) begin
          mem_re = 1'b1;
        end else if (host_req && host_mem) begin
          mem_re = 1'b1;
          mem_addr = host_idx[MEM_AW-1:0];
        end
      end
      S_SWRD: begin
        mem_re = 1'b1;
        mem_addr = sweep_idx_reg;
      end
      S_SWWR: begin
        mem_we = 1'b1;
        mem_addr = sweep_idx_reg;
        if (clear_all_reg) begin
          mem_wdata = MR_WORD;
        end else begin
          mem_wdata = mem_rdata & ~SOFTWARE_RESET_REQUEST_CLR_MASK;
        end
      end
      S_HRD: begin
        mem_we = 1'b1;
        mem_addr = host_idx[MEM_AW-1:0];
        mem_wdata = mem_rdata;
        mem_wdata[B_BLOCK_ACCESSED_FLAG] = 1'b0;
      end
      S_HWR: begin
        mem_we = 1'b1;
        mem_addr = host_idx[MEM_AW-1:0];
        mem_wdata = host_word;
      end
      S_DWR: begin
        mem_we = 1'b1;
        mem_wdata = done_word;
      end
      default: begin
        mem_re = 1'b0;
      end
    endcase
  end

  ctrl_word_ram #(.DW(DATA_W), .AW(MEM_AW)) u_ram (
    .ref_clk(ref_clk),
    .ce(ce),
    .re(mem_re),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  //////////////////////////////////////////////////////////////////////////
  // Sequencer; sweeps run first, then completions, starts, host
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= S_IDLE;
    end else if (ce) begin
      case (state_reg)
        S_IDLE: begin
          if (software_reset_request_pend_reg) begin
            state_reg <= S_SWRD;
          end else if (done_pend_reg) begin
            state_reg <= S_DRD;
          end else if (cmd_pend_reg) begin
            state_reg <= S_ERD;
          end else if (host_req && host_mem) begin
            state_reg <= read ? S_HRD : S_HWR;
          end else if (host_req) begin
            state_reg <= S_HACK;
          end
        end
        S_SWRD: state_reg <= S_SWWR;
        S_SWWR: state_reg <= (sweep_idx_reg == MEM_LAST) ? S_IDLE : S_SWRD;
        S_HRD: state_reg <= S_HACK;
        S_HWR: state_reg <= S_HACK;
        S_ERD: state_reg <= S_ELAT;
        S_DRD: state_reg <= S_DWR;
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // Sweep bookkeeping; master reset forces a full clearing sweep
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      software_reset_request_pend_reg <= 1'b1;
      clear_all_reg <= 1'b1;
      sweep_idx_reg <= MEM_FIRST;
    end else if (ce) begin
      if (state_reg == S_IDLE && software_reset_request_pend_reg) begin
        software_reset_request_pend_reg <= 1'b0;
        sweep_idx_reg <= MEM_FIRST;
      end else if (state_reg == S_SWWR) begin
        sweep_idx_reg <= sweep_idx_reg + 6'h01;
        if (sweep_idx_reg == MEM_LAST) begin
          clear_all_reg <= 1'b0;
        end
      end
      if (state_reg == S_HWR && host_idx == IDX_CFG) begin
        software_reset_request_pend_reg <= 1'b0;
      end
      if (state_reg == S_HACK && write && host_idx == IDX_CFG &&
          byteenable[0] && writedata[C_SOFTWARE_RESET_REQUEST]) begin
        software_reset_request_pend_reg <= 1'b1;
      end
    end
  end

  // Configuration register; software reset bit self-clears
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg_reg <= CFG_RESET;
    end else if (ce) begin
      if (state_reg == S_HACK && write && host_idx == IDX_CFG &&
          byteenable[0]) begin
        cfg_reg[C_SIMPLIFIED_MODE_PROCESSING] <= writedata[C_SIMPLIFIED_MODE_PROCESSING];
        cfg_reg[C_EXEC] <= writedata[C_EXEC];
      end
    end
  end

  // Read data, loaded one cycle before the answer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      readdata_reg <= {BUS_W{1'b0}};
    end else if (ce) begin
      if (state_reg == S_HRD) begin
        readdata_reg <= {{(BUS_W-DATA_W){1'b0}}, mem_rdata};
      end else if (state_reg == S_IDLE && read && !host_mem &&
                   !software_reset_request_pend_reg && !done_pend_reg && !cmd_pend_reg) begin
        if (host_idx == IDX_CFG) begin
          readdata_reg <= {{(BUS_W-DATA_W){1'b0}}, cfg_reg};
        end else if (host_idx == IDX_STAT) begin
          readdata_reg <= {{(BUS_W-5){1'b0}}, sel_mode_reg,
                           msg_active_reg, clear_all_reg};
        end else begin
          readdata_reg <= {BUS_W{1'b0}};
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Engine events wait here; a new event beats its own clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cmd_pend_reg <= 1'b0;
      done_pend_reg <= 1'b0;
      cmd_idx_reg <= MEM_FIRST;
      cmd_is_mode_reg <= 1'b0;
      cmd_mc_reg <= SA_MODE_LO;
      done_flags_reg <= 4'h0;
    end else if (ce) begin
      cmd_pend_reg <= cmd_start | (cmd_pend_reg & ~cmd_take);
      done_pend_reg <= msg_done | (done_pend_reg & ~done_take);
      if (cmd_start) begin
        cmd_is_mode_reg <= is_mode_cmd;
        cmd_mc_reg <= cmd_mode_code;
        if (is_mode_cmd) begin
          cmd_idx_reg <= IDX_MODE_BASE[MEM_AW-1:0] +
                         {1'b0, cmd_mode_code};
        end else begin
          cmd_idx_reg <= {1'b0, cmd_sa};
        end
      end
      if (msg_done) begin
        done_flags_reg <= {msg_broadcast_received_flag, msg_busy, msg_illegal, msg_error};
      end
    end
  end

  // Selection latched at command start, held until completion
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      msg_active_reg <= 1'b0;
      sel_mode_reg <= BUF_INDEXED;
      sel_buffer_b_reg <= 1'b0;
      sel_in_block_reg <= 1'b0;
      sel_live_reg <= 1'b0;
    end else if (ce) begin
      if (state_reg == S_ELAT) begin
        msg_active_reg <= 1'b1;
        sel_mode_reg <= lat_mode;
        sel_buffer_b_reg <= (lat_mode == BUF_PINGPONG) & mem_rdata[B_DPB];
        // Unacknowledged ping-pong serves the same buffer every time
        sel_live_reg <= mem_rdata[B_PINGPONG_ACTIVE_ACK];
        sel_in_block_reg <= (lat_mode == BUF_SIMPLIFIED) &&
                            (cmd_mc_reg >= MC_STORE_MIN);
      end else if (state_reg == S_DWR) begin
        msg_active_reg <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  property p_read_clear;
    @(posedge ref_clk) disable iff (rst)
    (ce && state_reg == S_HRD) |-> mem_we && !mem_wdata[B_BLOCK_ACCESSED_FLAG] &&
      (mem_wdata[B_PINGPONG_ENABLE] == mem_rdata[B_PINGPONG_ENABLE]);
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("host read did not clear block accessed");

  property p_host_ro;
    @(posedge ref_clk) disable iff (rst)
    (state_reg == S_HWR) |->
      mem_wdata[B_BLOCK_ACCESSED_FLAG:B_BROADCAST_RECEIVED_FLAG] == mem_rdata[B_BLOCK_ACCESSED_FLAG:B_BROADCAST_RECEIVED_FLAG];
  endproperty
  a_host_ro: assert property (p_host_ro)
    else $error("host wrote a device-owned bit");

  property p_exec_lock;
    @(posedge ref_clk) disable iff (rst)
    (state_reg == S_HWR && exec) |->
      mem_wdata[B_PINGPONG_ENABLE] == mem_rdata[B_PINGPONG_ENABLE];
  endproperty
  a_exec_lock: assert property (p_exec_lock)
    else $error("ping-pong enable changed while executing");

  property p_priority;
    @(posedge ref_clk) disable iff (rst)
    (ce && state_reg == S_ELAT && !cmd_is_mode_reg && mem_rdata[B_PINGPONG_ENABLE])
      |=> sel_mode_reg == BUF_PINGPONG && msg_active_reg;
  endproperty
  a_priority: assert property (p_priority)
    else $error("ping-pong did not win the mode priority");

  property p_simplified;
    @(posedge ref_clk) disable iff (rst)
    (ce && state_reg == S_ELAT && cmd_is_mode_reg && cfg_reg[C_SIMPLIFIED_MODE_PROCESSING])
      |=> sel_mode_reg == BUF_SIMPLIFIED && !sel_buffer_b_reg;
  endproperty
  a_simplified: assert property (p_simplified)
    else $error("simplified processing not selected");

  property p_toggle;
    @(posedge ref_clk) disable iff (rst)
    (state_reg == S_DWR && exec) |->
      (mem_wdata[B_DPB] != mem_rdata[B_DPB]) == toggle_ok &&
      mem_wdata[B_BLOCK_ACCESSED_FLAG];
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("next buffer bit or accessed bit wrong at completion");

  property p_mr_clear;
    @(posedge ref_clk) disable iff (rst)
    (state_reg == S_SWWR && clear_all_reg) |-> mem_wdata == MR_WORD;
  endproperty
  a_mr_clear: assert property (p_mr_clear)
    else $error("master reset sweep wrote a nonzero word");

  property p_sr_clear;
    @(posedge ref_clk) disable iff (rst)
    (state_reg == S_SWWR && !clear_all_reg) |->
      mem_wdata == (mem_rdata & ~SOFTWARE_RESET_REQUEST_CLR_MASK);
  endproperty
  a_sr_clear: assert property (p_sr_clear)
    else $error("software reset touched the wrong bits");

  property p_hold;
    @(posedge ref_clk) disable iff (rst)
    (msg_active_reg && state_reg != S_ELAT) |=>
      $stable(sel_mode_reg) || $past(state_reg) == S_ELAT;
  endproperty
  a_hold: assert property (p_hold)
    else $error("buffer mode changed during a message");

  property p_answer;
    @(posedge ref_clk) disable iff (rst)
    (state_reg == S_HWR || state_reg == S_HRD) |=> state_reg == S_HACK;
  endproperty
  a_answer: assert property (p_answer)
    else $error("host access not answered");

  c_toggle: cover property (@(posedge ref_clk) disable iff (rst)
    state_reg == S_DWR && exec && toggle_ok);
  c_read: cover property (@(posedge ref_clk) disable iff (rst)
    state_reg == S_HRD ##1 state_reg == S_HACK);
  c_software_reset_request: cover property (@(posedge ref_clk) disable iff (rst)
    state_reg == S_SWWR && !clear_all_reg);
  c_simple: cover property (@(posedge ref_clk) disable iff (rst)
    state_reg == S_ELAT && cfg_reg[C_SIMPLIFIED_MODE_PROCESSING] && cmd_is_mode_reg);
endmodule

/* File: tb/host_model.sv */
// Host side: Avalon-MM master reaching the control words
`timescale 1ns/100ps
module host_model
  import rt_ctrl_pkg::*;
(
  input wire logic ref_clk,
  output logic [ADDR_W-1:0] address,
  output logic read,
  output logic write,
  output logic [BUS_W-1:0] writedata,
  output logic [3:0] byteenable,
  input wire logic waitrequest,
  input wire logic [BUS_W-1:0] readdata
);
  initial begin
    address = '0;
    read = 1'b0;
    write = 1'b0;
    writedata = '0;
    byteenable = 4'hF;
  end

  // Request held until waitrequest seen low at an edge
  task automatic access(input logic wr, input logic [IDX_W-1:0] idx,
                        input logic [15:0] d, output logic [15:0] q);
    @(posedge ref_clk);
    address <= {idx, 2'b00};
    writedata <= {16'h0000, d};
    write <= wr;
    read <= !wr;
    do @(posedge ref_clk);
    while (waitrequest !== 1'b0);
    q = readdata[15:0];
    read <= 1'b0;
    write <= 1'b0;
    // Released lines show garbage, not the last value
    address <= ~address;
    writedata <= ~writedata;
  endtask
endmodule

/* File: tb/test_rt_buffer_mode_control_word.sv */
// Bench: host and engine stimulus against a reference model
`timescale 1ns/100ps
module test_rt_buffer_mode_control_word;
  import rt_ctrl_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic cmd_start = 1'b0;
  logic cmd_tr = 1'b0;
  logic [SA_W-1:0] cmd_sa = '0;
  logic [SA_W-1:0] cmd_mode_code = '0;
  logic msg_done = 1'b0;
  logic msg_error = 1'b0;
  logic msg_illegal = 1'b0;
  logic msg_busy = 1'b0;
  logic msg_broadcast_received_flag = 1'b0;
  logic [ADDR_W-1:0] address;
  logic read;
  logic write;
  logic [BUS_W-1:0] writedata;
  logic [3:0] byteenable;
  logic [BUS_W-1:0] readdata;
  logic waitrequest;
  logic sel_valid;
  buf_mode_e sel_mode;
  logic sel_buffer_b;
  logic sel_in_block;
  logic sel_pingpong_live;
  logic simplified_mode_processing;
  logic execution_start;
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  logic [15:0] mdl [0:63];
  logic [1:0] cfg = 2'b00;

  always #12.5 ref_clk = ~ref_clk;

  rt_buffer_mode_control_word i_rt_buffer_mode_control_word (.*);
  host_model i_host_model (.ref_clk(ref_clk), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .waitrequest(waitrequest),
    .readdata(readdata));

  //////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic [IDX_W-1:0] idx);
    logic [15:0] q;
    logic [15:0] e;
    e = 16'h0000;
    if (idx < IDX_MEM_END) e = mdl[idx[5:0]];
    if (idx == IDX_CFG) e = {14'h0000, cfg};
    i_host_model.access(1'b0, idx, 16'h0000, q);
    chk(q, e);
    if (idx < IDX_MEM_END) mdl[idx[5:0]][B_BLOCK_ACCESSED_FLAG] = 1'b0;
  endtask

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [15:0] d);
    logic [15:0] m;
    logic [15:0] q;
    int i;
    i = int'(idx[5:0]);
    m = cfg[1] ? 16'hF008 : 16'hF0FF;
    if (idx < IDX_MEM_END) begin
      mdl[i] = (mdl[i] & ~m) | (d & m);
      if (cfg[1]) mdl[i][B_PINGPONG_ACTIVE_ACK] = mdl[i][B_PINGPONG_ENABLE] & ~mdl[i][B_PINGPONG_SUSPEND_REQUEST];
    end else if (idx == IDX_CFG) begin
      cfg = d[1:0];
      if (d[2]) foreach (mdl[k]) mdl[k] &= ~SOFTWARE_RESET_REQUEST_CLR_MASK;
    end
    i_host_model.access(1'b1, idx, d, q);
  endtask

  // One message: start, check selection, finish after lag cycles
  task automatic msg(input logic tr, input logic [4:0] sa,
    input logic [4:0] mc, input logic [3:0] fl, input int lag);
    int n;
    int i;
    logic mw;
    logic [15:0] w;
    buf_mode_e em;
    mw = (sa == SA_MODE_LO || sa == SA_MODE_HI);
    i = mw ? 32 + int'(mc) : int'(sa);
    w = mdl[i];
    if (mw) em = cfg[0] ? BUF_SIMPLIFIED
      : w[B_PINGPONG_ENABLE] ? BUF_PINGPONG : BUF_INDEXED;
    else em = w[B_PINGPONG_ENABLE] ? BUF_PINGPONG : w[B_CIR2] ? BUF_CIRC2
      : w[B_CIR1] ? BUF_CIRC1 : BUF_INDEXED;
    @(posedge ref_clk);
    cmd_start <= 1'b1;
    cmd_tr <= tr;
    cmd_sa <= sa;
    cmd_mode_code <= mc;
    @(posedge ref_clk);
    cmd_start <= 1'b0;
    for (n = 0; n < 20 && sel_valid !== 1'b1; n++) @(posedge ref_clk);
    chk(16'(sel_valid), 16'h0001);
    chk(16'(sel_mode), 16'(em));
    chk(16'(sel_buffer_b), 16'(em == BUF_PINGPONG && w[B_DPB]));
    chk(16'(sel_in_block), 16'(cfg[0] && mw && mc >= 16));
    chk(16'(sel_pingpong_live), 16'(w[B_PINGPONG_ACTIVE_ACK]));
    repeat (lag) @(posedge ref_clk);
    chk(16'(sel_mode), 16'(em));
    msg_done <= 1'b1;
    {msg_error, msg_illegal, msg_busy, msg_broadcast_received_flag} <= fl;
    @(posedge ref_clk);
    msg_done <= 1'b0;
    for (n = 0; n < 20 && sel_valid !== 1'b0; n++) @(posedge ref_clk);
    chk(16'(sel_valid), 16'h0000);
    if (cfg[1]) begin
      if (em == BUF_PINGPONG && w[B_PINGPONG_ACTIVE_ACK] && fl[3:1] == 3'b000)
        mdl[i][B_DPB] = ~mdl[i][B_DPB];
      mdl[i][B_BLOCK_ACCESSED_FLAG] = 1'b1;
      mdl[i][B_BROADCAST_RECEIVED_FLAG] = mdl[i][B_BROADCAST_RECEIVED_FLAG] | fl[0];
      mdl[i][B_PINGPONG_ACTIVE_ACK] = mdl[i][B_PINGPONG_ENABLE] & ~mdl[i][B_PINGPONG_SUSPEND_REQUEST];
    end
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(93295));
    foreach (mdl[k]) mdl[k] = 16'h0000;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    rd(7'h00);
    rd(7'h25);
    rd(IDX_CFG);
    wr(7'h50, 16'hFFFF);
    rd(7'h50);
    $display("test reset done");
    for (int k = 0; k < 8; k++) begin
      wr(7'h05, (16'($urandom) & 16'hFFF8) | 16'(k));
      msg(1'($urandom), 5'h05, 5'($urandom), 4'h0, k);
    end
    $display("test subaddress modes done");
    for (int k = 0; k < 8; k++) begin
      wr(7'(32 + 2 * k), 16'(k));
      msg(1'b0, k[0] ? 5'h1F : 5'h00, 5'(2 * k), 4'h0, 0);
    end
    wr(IDX_CFG, 16'h0001);
    msg(1'b0, 5'h00, 5'h08, 4'h0, 2);
    msg(1'b0, 5'h1F, 5'h14, 4'h0, 0);
    wr(IDX_CFG, 16'h0000);
    $display("test mode words done");
    wr(7'h07, 16'h0004);
    wr(IDX_CFG, 16'h0002);
    wr(7'h07, 16'h0000);
    rd(7'h07);
    for (int f = 0; f < 5; f++) begin
      msg(1'b1, 5'h07, 5'h00, f == 0 ? 4'h0 : 4'(1 << (4 - f)), 3 * f);
      rd(7'h07);
    end
    rd(7'h07);
    wr(7'h07, 16'h0008);
    rd(7'h07);
    msg(1'b1, 5'h07, 5'h00, 4'h0, 0);
    rd(7'h07);
    wr(7'h07, 16'h0000);
    rd(7'h07);
    msg(1'b0, 5'h1F, 5'h08, 4'h0, 0);
    msg(1'b0, 5'h00, 5'h08, 4'h0, 1);
    rd(7'h28);
    $display("test ping-pong done");
    wr(IDX_CFG, 16'h0006);
    rd(7'h07);
    rd(7'h28);
    rd(IDX_CFG);
    $display("test software reset done");
    @(posedge ref_clk);
    ce <= 1'b0;
    cmd_start <= 1'b1;
    cmd_sa <= 5'h07;
    @(posedge ref_clk);
    cmd_start <= 1'b0;
    repeat (2) @(posedge ref_clk);
    ce <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk(16'(sel_valid), 16'h0000);
    rd(IDX_CFG);
    $display("test clock enable done");
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (mdl[k]) mdl[k] = 16'h0000;
    cfg = 2'b00;
    rd(7'h07);
    rd(7'h28);
    rd(IDX_CFG);
    $display("test master reset done");
    tally_and_finish();
  end
endmodule
